/* File: design/cbc_bus_cycles.v */
// cpu-side generator of input read and memory write bus cycles
// Operation
// - io device number on both address halves
// - late t1: address, status, sync together
// - sync prepares the status strobe for t2
// - t2 start: status strobe loads status latch
// - input read raises latched input status
// - late t2 into t3: data-in strobe high
// - gate data in by strobe and panel gate
// - increment program counter ending input read
// - store accumulator: fetch, two address reads, write
// - memory write takes exactly three t periods
// - output status stays low in memory write
// - write status low, inverted lights write indicator
// - t3 start: drive data out onto bus
// - write strobe only after data settles
// - memory write strobe from strobe and output status
`timescale 1ns/1ps
`include "cbc_map.vh"
module cbc_bus_cycles #(
  parameter TPER = `CBC_TPER_DEF
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // backplane address and sync
  output reg [15:0] addr_o,
  output reg bus_sync_o,
  // backplane status lines
  output wire memory_read_status_o,
  output wire input_status_o,
  output wire output_status_o,
  output wire write_output_status_n_o,
  // backplane strobes
  output reg bus_data_in_strobe_o,
  output reg bus_write_strobe_n_o,
  output reg memory_write_strobe_o,
  // data buses
  input wire [7:0] data_in_i,
  output reg [7:0] data_out_o,
  output reg data_out_oe_o,
  // front panel
  input wire panel_data_in_gate_i,
  output reg write_indicator_o,
  output reg input_indicator_o,
  // internal processor-side strobes, visible for debug
  output reg status_strobe_n_o,
  output reg buffer_data_in_enable_n_o
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_T1 = 2'd1;
  localparam [1:0] S_T2 = 2'd2;
  localparam [1:0] S_T3 = 2'd3;
  localparam [7:0] SUB_LAST = TPER[7:0] - 8'h01;
  localparam [7:0] SUB_HALF = TPER[8:1];

  wire [8:0] sync_w;
  wire [7:0] din_w;
  wire gate_pin_w;
  wire [7:0] latched_w;

  reg [1:0] state_q;
  reg [7:0] sub_q;
  reg [1:0] mcyc_q;
  reg [1:0] op_q;
  reg panel_q;
  reg busy_q;
  reg done_q;
  reg [15:0] addr_reg_q;
  reg [7:0] wdata_q;
  reg [7:0] rdata_q;
  reg [15:0] pc_q;
  reg [15:0] tgt_q;
  reg [7:0] stbyte_q;
  reg is_write_q;

  wire acc_w = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr_w = acc_w & wb_we_i;
  wire go_w = wr_w & (wb_adr_i == `CBC_OFF_CTRL) & wb_sel_i[0] &
    wb_dat_i[`CBC_CTRL_GO] & ~busy_q;
  wire end_t_w = (sub_q == SUB_LAST);
  wire finish_w;
  wire gate_w;

  // panel and data pins come from other cards, so they are synchronised
  cbc_sync2 #(
    .W(9),
    .INIT(9'h100)
  ) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .pin_i({panel_data_in_gate_i, data_in_i}),
    .sync_o(sync_w)
  );
  assign din_w = sync_w[7:0];
  assign gate_pin_w = sync_w[8];
  // with no panel fitted the pin is ignored and the gate reads high
  assign gate_w = panel_q ? gate_pin_w : 1'b1;

  cbc_stlatch u_latch (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .status_strobe_n_i(status_strobe_n_o),
    .status_i(stbyte_q),
    .latched_o(latched_w)
  );
  assign memory_read_status_o = latched_w[`CBC_ST_MEMR];
  assign input_status_o = latched_w[`CBC_ST_INSTAT];
  assign output_status_o = latched_w[`CBC_ST_OUT];
  assign write_output_status_n_o = latched_w[`CBC_ST_WRSTAT_N];

  assign finish_w = (state_q == S_T3) & end_t_w &
    ((op_q != `CBC_OP_STORE) | (mcyc_q == `CBC_LAST_MCYC));

  // wishbone: ack one cycle after the request, dropped the cycle after
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= acc_w;
      wb_dat_o <= 32'h0000_0000;
      if (acc_w && !wb_we_i) begin
        case (wb_adr_i)
          `CBC_OFF_CTRL: wb_dat_o <= {28'h000_0000, panel_q, 1'b0, op_q};
          `CBC_OFF_ADDR: wb_dat_o <= {16'h0000, addr_reg_q};
          `CBC_OFF_WDATA: wb_dat_o <= {24'h00_0000, wdata_q};
          `CBC_OFF_STAT: wb_dat_o <= {30'h0000_0000, done_q, busy_q};
          `CBC_OFF_RDATA: wb_dat_o <= {24'h00_0000, rdata_q};
          `CBC_OFF_PC: wb_dat_o <= {16'h0000, pc_q};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // software registers; writes while busy to ctrl are ignored
  always @(posedge clk_i) begin
    if (rst_i) begin
      panel_q <= 1'b0;
      addr_reg_q <= 16'h0000;
      wdata_q <= 8'h00;
    end else if (wr_w) begin
      if (wb_adr_i == `CBC_OFF_CTRL && wb_sel_i[0] && !busy_q) begin
        panel_q <= wb_dat_i[`CBC_CTRL_PANEL];
      end
      if (wb_adr_i == `CBC_OFF_ADDR) begin
        if (wb_sel_i[0]) begin
          addr_reg_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          addr_reg_q[15:8] <= wb_dat_i[15:8];
        end
      end
      if (wb_adr_i == `CBC_OFF_WDATA && wb_sel_i[0]) begin
        wdata_q <= wb_dat_i[7:0];
      end
    end
  end

  // done: set by the hardware wins over a clearing start in the same cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
    end else if (finish_w) begin
      done_q <= 1'b1;
    end else if (go_w) begin
      done_q <= 1'b0;
    end
  end

  // machine cycle sequencer
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= S_IDLE;
      sub_q <= 8'h00;
      mcyc_q <= 2'h0;
      op_q <= `CBC_OP_INPUT;
      busy_q <= 1'b0;
      stbyte_q <= `CBC_SB_RESET;
      is_write_q <= 1'b0;
    end else begin
      case (state_q)
        S_IDLE: begin
          sub_q <= 8'h00;
          mcyc_q <= 2'h0;
          if (go_w) begin
            op_q <= wb_dat_i[`CBC_CTRL_OP_HI:`CBC_CTRL_OP_LO];
            busy_q <= 1'b1;
            state_q <= S_T1;
            case (wb_dat_i[`CBC_CTRL_OP_HI:`CBC_CTRL_OP_LO])
              `CBC_OP_INPUT: begin
                stbyte_q <= `CBC_SB_INPUT;
                is_write_q <= 1'b0;
              end
              `CBC_OP_MEMWR: begin
                stbyte_q <= `CBC_SB_MEMWR;
                is_write_q <= 1'b1;
              end
              default: begin
                stbyte_q <= `CBC_SB_FETCH;
                is_write_q <= 1'b0;
              end
            endcase
          end
        end
        S_T1: begin
          sub_q <= end_t_w ? 8'h00 : sub_q + 8'h01;
          if (end_t_w) begin
            state_q <= S_T2;
          end
        end
        S_T2: begin
          sub_q <= end_t_w ? 8'h00 : sub_q + 8'h01;
          if (end_t_w) begin
            state_q <= S_T3;
          end
        end
        S_T3: begin
          sub_q <= end_t_w ? 8'h00 : sub_q + 8'h01;
          if (finish_w) begin
            // exactly three t periods per machine cycle
            state_q <= S_IDLE;
            busy_q <= 1'b0;
          end else if (end_t_w) begin
            // store accumulator: m2, m3 read the target, m4 writes
            mcyc_q <= mcyc_q + 2'h1;
            state_q <= S_T1;
            if (mcyc_q == 2'h2) begin
              stbyte_q <= `CBC_SB_MEMWR;
              is_write_q <= 1'b1;
            end else begin
              stbyte_q <= `CBC_SB_MEMRD;
            end
          end
        end
        default: begin
          state_q <= S_IDLE;
          busy_q <= 1'b0;
        end
      endcase
    end
  end

  // address selection for each machine cycle
  always @(posedge clk_i) begin
    if (rst_i) begin
      addr_o <= 16'h0000;
    end else if (state_q == S_T1 && sub_q == 8'h00) begin
      if (op_q == `CBC_OP_INPUT) begin
        addr_o <= {addr_reg_q[7:0], addr_reg_q[7:0]};
      end else if (op_q == `CBC_OP_MEMWR) begin
        addr_o <= addr_reg_q;
      end else if (mcyc_q == `CBC_LAST_MCYC) begin
        addr_o <= tgt_q;
      end else begin
        addr_o <= pc_q;
      end
    end
  end

  // pin timing within t1..t3
  always @(posedge clk_i) begin
    if (rst_i) begin
      bus_sync_o <= 1'b0;
      status_strobe_n_o <= 1'b1;
      bus_data_in_strobe_o <= 1'b0;
      bus_write_strobe_n_o <= 1'b1;
      data_out_o <= 8'h00;
      data_out_oe_o <= 1'b0;
      buffer_data_in_enable_n_o <= 1'b0;
    end else begin
      // late t1: status on the buffers with sync, address already out
      bus_sync_o <= (state_q == S_T1) && (sub_q >= SUB_HALF);
      // sync seen high arms the strobe for the first clock of t2
      status_strobe_n_o <= ~(bus_sync_o && state_q == S_T1 && end_t_w);
      // data-in strobe spans late t2 into early t3 of read cycles
      bus_data_in_strobe_o <= !is_write_q && state_q != S_IDLE &&
        ((state_q == S_T2 && sub_q >= SUB_HALF - 8'h01 && !end_t_w) ||
         (state_q == S_T2 && end_t_w) ||
         (state_q == S_T3 && sub_q < SUB_HALF - 8'h01));
      // buffers turn inward only in the data-in window; low lets the
      // status byte and the write data pass outward
      buffer_data_in_enable_n_o <= !is_write_q &&
        ((state_q == S_T2 && sub_q >= SUB_HALF - 8'h01) ||
         (state_q == S_T3 && sub_q < SUB_HALF - 8'h01));
      if (state_q == S_T1) begin
        data_out_o <= stbyte_q;
        data_out_oe_o <= 1'b1;
      end else if (is_write_q && state_q == S_T2 && end_t_w) begin
        // t3 opens with the data byte on the bus
        data_out_o <= wdata_q;
        data_out_oe_o <= 1'b1;
      end else if (!(is_write_q && state_q == S_T3 && !end_t_w)) begin
        data_out_oe_o <= 1'b0;
      end
      // one clock after data; ends early so the lagging memory strobe fits
      bus_write_strobe_n_o <= ~(is_write_q && state_q == S_T3 &&
        sub_q < SUB_LAST - 8'h01);
    end
  end

  // memory write strobe: both inverted into a nand, then a nor
  always @(posedge clk_i) begin
    if (rst_i) begin
      memory_write_strobe_o <= 1'b0;
    end else begin
      memory_write_strobe_o <= ~(~(~bus_write_strobe_n_o &
        ~output_status_o) | 1'b0);
    end
  end

  // panel indicators follow the latched status
  always @(posedge clk_i) begin
    if (rst_i) begin
      write_indicator_o <= 1'b0;
      input_indicator_o <= 1'b0;
    end else begin
      write_indicator_o <= ~write_output_status_n_o;
      input_indicator_o <= input_status_o;
    end
  end

  // data capture at the next-to-last strobe clock of t3, then pc advance
  always @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
      tgt_q <= 16'h0000;
      pc_q <= 16'h0000;
    end else begin
      if (state_q == S_T3 && !is_write_q && bus_data_in_strobe_o &&
          gate_w && sub_q == SUB_HALF - 8'h02) begin
        // the card holds its byte while the strobe is up
        if (op_q == `CBC_OP_STORE && mcyc_q == 2'h1) begin
          tgt_q[7:0] <= din_w;
        end else if (op_q == `CBC_OP_STORE && mcyc_q == 2'h2) begin
          tgt_q[15:8] <= din_w;
        end else begin
          rdata_q <= din_w;
        end
      end
      if (wr_w && wb_adr_i == `CBC_OFF_PC && !busy_q) begin
        if (wb_sel_i[0]) begin
          pc_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          pc_q[15:8] <= wb_dat_i[15:8];
        end
      end else if (state_q == S_T3 && end_t_w && op_q != `CBC_OP_MEMWR &&
          !is_write_q) begin
        pc_q <= pc_q + 16'h0001;
      end
    end
  end
endmodule

/* File: design/cbc_map.vh */
// constants for the cpu-side bus cycle generator
`ifndef CBC_MAP_VH
`define CBC_MAP_VH

// wishbone register byte offsets
`define CBC_OFF_CTRL 6'h00
`define CBC_OFF_ADDR 6'h04
`define CBC_OFF_WDATA 6'h08
`define CBC_OFF_STAT 6'h0C
`define CBC_OFF_RDATA 6'h10
`define CBC_OFF_PC 6'h14

// control register fields
`define CBC_CTRL_OP_LO 0
`define CBC_CTRL_OP_HI 1
`define CBC_CTRL_GO 2
`define CBC_CTRL_PANEL 3

// operations
`define CBC_OP_INPUT 2'h0
`define CBC_OP_MEMWR 2'h1
`define CBC_OP_STORE 2'h2

// status byte bit positions
`define CBC_ST_MEMR 7
`define CBC_ST_INSTAT 6
`define CBC_ST_M1 5
`define CBC_ST_OUT 4
`define CBC_ST_WRSTAT_N 1

// status byte values per cycle kind
`define CBC_SB_FETCH 8'hA2
`define CBC_SB_MEMRD 8'h82
`define CBC_SB_INPUT 8'h42
`define CBC_SB_MEMWR 8'h00
// all inactive: write_output_status_n high, the rest low
`define CBC_SB_RESET 8'h02

// status register fields
`define CBC_STAT_BUSY 0
`define CBC_STAT_DONE 1

// machine cycle limit for store accumulator (m1..m4)
`define CBC_LAST_MCYC 2'h3
`define CBC_TPER_DEF 4

`endif

/* File: design/cbc_stlatch.v */
// status latch loaded by the active-low status strobe
`timescale 1ns/1ps
`include "cbc_map.vh"
module cbc_stlatch (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // strobe and status byte
  input wire status_strobe_n_i,
  input wire [7:0] status_i,
  // latched status lines
  output reg [7:0] latched_o
);
  always @(posedge clk_i) begin
    if (rst_i) begin
      latched_o <= `CBC_SB_RESET;
    end else if (!status_strobe_n_i) begin
      latched_o <= status_i;
    end
  end
endmodule

/* File: design/cbc_sync2.v */
// two-flop synchroniser for a vector of pin inputs
`timescale 1ns/1ps
module cbc_sync2 #(
  parameter W = 9,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // pins and synchronised copy
  input wire [W-1:0] pin_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= INIT;
      sync_o <= INIT;
    end else begin
      meta_q <= pin_i;
      sync_o <= meta_q;
    end
  end
endmodule

/* File: testbench/cbc_bus_cycles_tb.sv */
// self-checking bench for the cpu-side bus cycle generator
`timescale 1ns/1ps
module cbc_bus_cycles_tb;
  logic clk_i = 0;
  logic rst_i = 1;
  logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [5:0] wb_adr_i = 0;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 0, q;
  logic panel_data_in_gate_i = 0;
  logic [7:0] io_byte = 8'hFF;
  wire [31:0] wb_dat_o;
  wire [15:0] addr_o;
  wire [7:0] data_in_i, data_out_o;
  wire wb_ack_o, bus_sync_o, memory_read_status_o, input_status_o;
  wire output_status_o, write_output_status_n_o, bus_data_in_strobe_o;
  wire bus_write_strobe_n_o, memory_write_strobe_o, data_out_oe_o;
  wire write_indicator_o, input_indicator_o, status_strobe_n_o;
  wire buffer_data_in_enable_n_o;
  int err_count = 0, comparisons = 0, cycles = 0, sync_cnt = 0, n0;
  logic sync_prev = 0, seen_input = 0, seen_memr = 0;
  logic [15:0] seen_addr = 0;

  cbc_bus_cycles i_dut (.*);
  cbc_card_model i_card (.clk_i(clk_i), .addr_i(addr_o),
    .input_status_i(input_status_o), .data_in_strobe_i(bus_data_in_strobe_o),
    .mem_wr_i(memory_write_strobe_o), .data_out_i(data_out_o),
    .io_byte_i(io_byte), .data_in_o(data_in_i));

  always #5 clk_i = ~clk_i;

  task automatic conclude();
    $display("comparisons %0d errors %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask

  // one classic cycle; released only after the edge that saw ack
  task automatic wb(input logic w, input logic [5:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
  endtask

  task automatic run(input logic [3:0] ctrl);
    wb(1, 6'h00, {28'h000_0000, ctrl});
    do wb(0, 6'h0C, 32'h0); while (q[1] !== 1'b1);
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    sync_prev <= bus_sync_o;
    if (bus_sync_o === 1'b1 && sync_prev === 1'b0)
      sync_cnt <= sync_cnt + 1;
    if (input_status_o === 1'b1) begin
      seen_addr <= addr_o;
      seen_input <= 1;
    end
    if (memory_read_status_o === 1'b1)
      seen_memr <= 1;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  initial begin
    i_card.mem[16'h0300] = 8'h32;
    i_card.mem[16'h0301] = 8'h78;
    i_card.mem[16'h0302] = 8'h56;
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("idle lines", 32'h22, {write_output_status_n_o, input_status_o,
      output_status_o, memory_write_strobe_o, bus_write_strobe_n_o,
      bus_data_in_strobe_o});
    wb(0, 6'h3C, 32'h0);
    chk("unmapped read", 32'h0, q);
    // input read with no panel: the low gate pin must be ignored
    wb(1, 6'h04, 32'h0000_0037);
    wb(1, 6'h14, 32'h0000_0200);
    io_byte <= 8'h5A;
    run(4'h4);
    wb(0, 6'h10, 32'h0);
    chk("input byte", 32'h5A, q);
    chk("device address", 32'h3737, seen_addr);
    chk("input status", 32'h1, seen_input);
    chk("input lamp", 32'h1, input_indicator_o);
    wb(0, 6'h14, 32'h0);
    chk("pc after input", 32'h0201, q);
    io_byte <= 8'hA5;
    for (int i = 0; i < 2; i++) begin
      panel_data_in_gate_i <= i[0];
      run(4'hC);
      wb(0, 6'h10, 32'h0);
      chk("gated byte", i ? 32'hA5 : 32'h5A, q);
    end
    wb(1, 6'h04, 32'h0000_1234);
    wb(1, 6'h08, 32'h0000_00C3);
    n0 = sync_cnt;
    run(4'h5);
    chk("memory write", 32'hC3, i_card.mem[16'h1234]);
    chk("write cycles", 32'h1, sync_cnt - n0);
    chk("write lamp", 32'h1, write_indicator_o);
    wb(1, 6'h14, 32'h0000_0300);
    wb(1, 6'h08, 32'h0000_0099);
    n0 = sync_cnt;
    run(4'h6);
    chk("store target", 32'h99, i_card.mem[16'h5678]);
    chk("store cycles", 32'h4, sync_cnt - n0);
    chk("read status", 32'h1, seen_memr);
    wb(0, 6'h14, 32'h0);
    chk("pc after store", 32'h0303, q);
    conclude();
  end
endmodule

/* File: testbench/cbc_bus_props.sv */
// port assertions for the cpu-side bus cycle generator
`timescale 1ns/1ps
module cbc_bus_props (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // watched outputs
  input wire wb_ack_o,
  input wire bus_sync_o,
  input wire input_status_o,
  input wire output_status_o,
  input wire write_output_status_n_o,
  input wire bus_data_in_strobe_o,
  input wire bus_write_strobe_n_o,
  input wire memory_write_strobe_o,
  input wire [7:0] data_out_o,
  input wire data_out_oe_o,
  input wire buffer_data_in_enable_n_o,
  input wire write_indicator_o,
  input wire status_strobe_n_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  reset_idle_a: assert property (disable iff (1'b0) rst_i |=>
    write_output_status_n_o && bus_write_strobe_n_o && !input_status_o
    && !memory_write_strobe_o && !bus_data_in_strobe_o)
    else $error("lines not idle after reset");
  sync_strobe_a: assert property ($rose(bus_sync_o) |->
    ##[1:3] !status_strobe_n_o)
    else $error("no status strobe after sync");
  strobe_pulse_a: assert property ($fell(status_strobe_n_o) |->
    ($past(bus_sync_o) || $past(bus_sync_o, 2)) ##1 status_strobe_n_o)
    else $error("status strobe not a single pulse after sync");
  mem_strobe_a: assert property (memory_write_strobe_o ==
    (!$past(bus_write_strobe_n_o) && !$past(output_status_o)))
    else $error("memory write strobe gating wrong");
  write_no_out_a: assert property (!bus_write_strobe_n_o |->
    !output_status_o)
    else $error("output status high during memory write");
  write_data_a: assert property (!bus_write_strobe_n_o |->
    data_out_oe_o && $stable(data_out_o))
    else $error("write strobe without settled data");
  write_lamp_a: assert property (write_indicator_o ==
    !$past(write_output_status_n_o))
    else $error("write indicator not inverse of write status");
  data_in_dir_a: assert property (bus_data_in_strobe_o |->
    bus_write_strobe_n_o && !data_out_oe_o)
    else $error("data-in strobe while driving out");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  status_dir_a: assert property (data_out_oe_o |->
    !buffer_data_in_enable_n_o)
    else $error("buffers turned inward while driving out");
  write_hold_a: assert property (memory_write_strobe_o |->
    data_out_oe_o)
    else $error("memory write strobe without driven data");
endmodule

bind cbc_bus_cycles cbc_bus_props u_props (.*);

/* File: testbench/cbc_card_model.sv */
// behavioural memory card and input card on the backplane
`timescale 1ns/1ps
module cbc_card_model (
  // clock
  input wire clk_i,
  // bus from the cpu card
  input wire [15:0] addr_i,
  input wire input_status_i,
  input wire data_in_strobe_i,
  input wire mem_wr_i,
  input wire [7:0] data_out_i,
  // byte the input card returns
  input wire [7:0] io_byte_i,
  output wire [7:0] data_in_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  wire [7:0] cur = input_status_i ? io_byte_i : mem[addr_i];
  // released lines show the inverse so stale data never passes as new
  assign data_in_o = data_in_strobe_i ? cur : ~last_q;
  always @(posedge clk_i) begin
    if (data_in_strobe_i)
      last_q <= cur;
    if (mem_wr_i)
      mem[addr_i] <= data_out_i;
  end
endmodule
